// file: core/can_lowpower_and_length.sv
// Top: APB registers, message buffer, frame byte feed and low-power mode control
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module can_lowpower_and_length
(
  input  wire logic        pclk,        // Clock, 250 MHz
  input  wire logic        presetn,     // Async reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  input  wire logic [2:0]  cpu_mode_in, // Processor mode, from outside domain
  input  wire logic        tx_byte_take,// Frame engine takes current byte
  output logic             tx_active,   // Frame in progress
  output logic             tx_remote,   // Current frame is remote
  output logic      [3:0]  tx_length,   // Length code sent on the wire
  output logic             tx_byte_valid,// A data byte is offered
  output logic      [7:0]  byte_value,  // Offered data byte
  output logic             engine_restart,// Restart pulse to frame engine
  output logic      [1:0]  mode_out,    // Present controller mode
  output logic             irq          // Interrupt, active high
);
  can_lp_mode_if mi ();

  logic [7:0]            msg_data_bytes [8];  // Data bytes 0..7
  logic [3:0]            msg_length;          // Data length code
  logic [2:0]            ctrl;                // Enable, stop-in-wait, sleep request
  logic [can_lp_pkg::IRQ_W-1:0] irq_stat;     // Sticky events
  logic [can_lp_pkg::IRQ_W-1:0] irq_mask;     // Event mask
  logic [can_lp_pkg::IRQ_W-1:0] events;       // Event pulses this cycle
  logic [2:0]            cpu_s1;              // Synchroniser stage one
  logic [2:0]            cpu_s2;              // Synchroniser stage two
  logic [3:0]            byte_cnt;            // Bytes still to send
  logic [2:0]            byte_idx;            // Index of next byte
  logic                  wr_acc;              // APB write access
  logic                  rd_acc;              // APB read access
  logic                  addr_ok;             // Address maps
  logic                  go;                  // Start frame strobe
  logic                  tx_done_ev;          // Frame finished
  logic [3:0]            next_count;          // Bytes for new frame
  logic [31:0]           next_rdata;          // Read mux
  can_lp_pkg::can_mode_t prev_mode;           // Mode last cycle

  // Access phase qualifiers; a transfer lands at its access edge
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign go     = wr_acc && (paddr == can_lp_pkg::OFF_TX_CMD);

  // Address decode
  always_comb
  begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr <= can_lp_pkg::OFF_TX_CMD);
  end

  // Processor mode passes two flip-flops
  // Only the second stage is read, so a changing
  // Mode code never reaches the mode table half-settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_s1 <= 3'h0;
      cpu_s2 <= 3'h0;
    end
    else
    begin
      cpu_s1 <= cpu_mode_in;
      cpu_s2 <= cpu_s1;
    end
  end

  // Control bits drive the mode selector directly
  assign mi.enable    = ctrl[can_lp_pkg::CTRL_ENABLE];
  assign mi.swai      = ctrl[can_lp_pkg::CTRL_SWAI];
  assign mi.sleep_req = ctrl[can_lp_pkg::CTRL_SLEEP_REQUEST];
  assign mi.cpu_mode  = cpu_s2;

  can_lp_mode_sel u_sel
  (
    .pclk    (pclk),
    .presetn (presetn),
    .m       (mi)
  );

  // Control register
  // Resets with the controller enabled, no sleep asked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= can_lp_pkg::CTRL_RST;
    else if (wr_acc && paddr == can_lp_pkg::OFF_CTRL)
      ctrl <= pwdata[2:0];
  end

  // Length register, four low bits kept
  // Upper bits of a write are dropped; frozen during a frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      msg_length <= can_lp_pkg::LENGTH_RST;
    else if (wr_acc && paddr == can_lp_pkg::OFF_LENGTH && !tx_active)
      msg_length <= pwdata[can_lp_pkg::LEN_MSB:0];
  end

  // Data bytes, locked while a frame runs
  // Word index from address bits 4:2, low byte only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        msg_data_bytes[i] <= can_lp_pkg::DATA_RST;
    end
    else if (wr_acc && paddr < can_lp_pkg::OFF_LENGTH && !tx_active)
      msg_data_bytes[paddr[4:2]] <= pwdata[7:0];
  end

  // Byte count for a new frame
  // Remote frames carry none; codes above eight feed eight
  always_comb
  begin
    if (pwdata[0])
      next_count = 4'h0;
    else if (msg_length > can_lp_pkg::MAX_BYTES)
      next_count = can_lp_pkg::MAX_BYTES;
    else
      next_count = msg_length;
  end

  // Frame byte feed to the engine
  // One byte stands until the engine takes it at an edge;
  // The next byte follows in the cycle after
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_active     <= 1'b0;
      tx_remote     <= 1'b0;
      tx_length     <= 4'h0;
      byte_cnt      <= 4'h0;
      byte_idx      <= 3'h0;
      tx_byte_valid <= 1'b0;
      byte_value    <= 8'h00;
      tx_done_ev    <= 1'b0;
    end
    else
    begin
      tx_done_ev <= 1'b0;
      if (mi.restart || mi.mode != can_lp_pkg::M_NORMAL)
      begin
        // Abort on low power; restart clears engines
        tx_active     <= 1'b0;
        tx_byte_valid <= 1'b0;
        byte_cnt      <= 4'h0;
      end
      // New frame: length code and first byte loaded together
      else if (go && !tx_active)
      begin
        tx_active     <= 1'b1;
        tx_remote     <= pwdata[0];
        tx_length     <= msg_length;
        byte_cnt      <= next_count;
        byte_idx      <= 3'h0;
        tx_byte_valid <= (next_count != 4'h0);
        byte_value    <= msg_data_bytes[0];
        tx_done_ev    <= (next_count == 4'h0);
        if (next_count == 4'h0)
          tx_active <= 1'b0;
      end
      // Byte taken: step to the next, end after the last
      else if (tx_active && tx_byte_valid && tx_byte_take)
      begin
        byte_cnt   <= byte_cnt - 4'h1;
        byte_idx   <= byte_idx + 3'h1;
        byte_value <= msg_data_bytes[3'(byte_idx + 3'h1)];
        if (byte_cnt == 4'h1)
        begin
          tx_byte_valid <= 1'b0;
          tx_active     <= 1'b0;
          tx_done_ev    <= 1'b1;
        end
      end
    end
  end

  // Mode history and pass-through outputs
  // Outputs lag the internal mode by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_mode      <= can_lp_pkg::M_DISABLED;
      mode_out       <= 2'h3;
      engine_restart <= 1'b0;
    end
    else
    begin
      prev_mode      <= mi.mode;
      mode_out       <= mi.mode;
      engine_restart <= mi.restart;
    end
  end

  // Event pulses
  // Mode events fire on entry only, not while held
  always_comb
  begin
    events = '0;
    events[can_lp_pkg::IRQ_SLEEP]  = (mi.mode == can_lp_pkg::M_SLEEP) && (prev_mode != can_lp_pkg::M_SLEEP);
    events[can_lp_pkg::IRQ_PDOWN]  = (mi.mode == can_lp_pkg::M_PDOWN) && (prev_mode != can_lp_pkg::M_PDOWN);
    events[can_lp_pkg::IRQ_WAKE]   = mi.restart;
    events[can_lp_pkg::IRQ_TXDONE] = tx_done_ev;
  end

  // Sticky status, set wins over clear
  // A clear and a new event in one cycle keep the bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= '0;
    else if (wr_acc && paddr == can_lp_pkg::OFF_IRQ_STAT)
      irq_stat <= (irq_stat & ~pwdata[can_lp_pkg::IRQ_W-1:0]) | events;
    else
      irq_stat <= irq_stat | events;
  end

  // Mask register
  // Masked events still set their status bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= can_lp_pkg::MASK_RST;
    else if (wr_acc && paddr == can_lp_pkg::OFF_IRQ_MASK)
      irq_mask <= pwdata[can_lp_pkg::IRQ_W-1:0];
  end

  // Interrupt line, normal-mode interrupts work in wait too
  // Registered so the pin comes straight from a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // Read mux
  // Unmapped offsets from 0x20 up and write-only offsets read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (paddr < can_lp_pkg::OFF_LENGTH)
      next_rdata = {24'h000000, msg_data_bytes[paddr[4:2]]};
    else
    begin
      unique case (paddr)
        can_lp_pkg::OFF_LENGTH:   next_rdata = {28'h0000000, msg_length};
        can_lp_pkg::OFF_CTRL:     next_rdata = {29'h00000000, ctrl};
        can_lp_pkg::OFF_STATUS:   next_rdata = {28'h0000000, tx_active, mi.mode, mi.sleep_ack};
        can_lp_pkg::OFF_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
        can_lp_pkg::OFF_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
        default:                  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // APB answer: no wait states, error for unmapped
  // Ready rises in the first access cycle of every transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end
endmodule : can_lowpower_and_length
`default_nettype wire

// file: core/can_lp_mode_if.sv
// Interface between bus side and mode selector
`timescale 1ns/1ps
`default_nettype none
interface can_lp_mode_if;
  logic                 enable;     // Controller enable
  logic                 swai;       // Stop in wait
  logic                 sleep_req;  // Sleep request
  logic [2:0]           cpu_mode;   // Synchronised processor mode
  logic                 sleep_ack;  // Sleep acknowledge
  can_lp_pkg::can_mode_t mode;      // Present controller mode
  logic                 restart;    // One-cycle pulse on wake from power-down
  modport ctl (output enable, swai, sleep_req, cpu_mode, input sleep_ack, mode, restart);
  modport sel (input enable, swai, sleep_req, cpu_mode, output sleep_ack, mode, restart);
endinterface : can_lp_mode_if
`default_nettype wire

// file: core/can_lp_mode_sel.sv
// Mode selector: picks normal, sleep, power-down or disabled from processor mode and control bits
`timescale 1ns/1ps
`default_nettype none
module can_lp_mode_sel
(
  input  wire logic   pclk,    // Clock
  input  wire logic   presetn, // Async reset, active low
  can_lp_mode_if.sel  m        // Mode signals
);
  logic [3:0]            ack_cnt;    // Handshake counter
  logic                  stop3_slp;  // Sleep armed at stop3 entry
  can_lp_pkg::can_mode_t next_mode;  // Mode chosen this cycle
  can_lp_pkg::cpu_mode_t cm;         // Processor mode as enum

  assign cm = can_lp_pkg::cpu_mode_t'(m.cpu_mode);

  // Sleep acknowledge follows request after a short delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_cnt     <= 4'h0;
      m.sleep_ack <= 1'b0;
    end
    else if (!m.sleep_req || !m.enable)
    begin
      ack_cnt     <= 4'h0;
      m.sleep_ack <= 1'b0;
    end
    else if (ack_cnt != can_lp_pkg::ACK_CYCLES)
      ack_cnt <= ack_cnt + 4'h1;
    else
      m.sleep_ack <= 1'b1;
  end

  // Stop3 choice is fixed by the bits present before entry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop3_slp <= 1'b0;
    else if (cm != can_lp_pkg::CPU_STOP3)
      stop3_slp <= m.sleep_req && m.sleep_ack;
  end

  // Mode decision table
  always_comb
  begin
    next_mode = can_lp_pkg::M_NORMAL;
    if (!m.enable)
      next_mode = can_lp_pkg::M_DISABLED;
    else
    begin
      unique case (cm)
        can_lp_pkg::CPU_RUN:
          // Only sleep is offered in run
          next_mode = (m.sleep_req && m.sleep_ack) ? can_lp_pkg::M_SLEEP : can_lp_pkg::M_NORMAL;
        can_lp_pkg::CPU_WAIT:
          if (m.swai)
            next_mode = can_lp_pkg::M_PDOWN;
          else if (m.sleep_req && m.sleep_ack)
            next_mode = can_lp_pkg::M_SLEEP;
          else
            next_mode = can_lp_pkg::M_NORMAL;
        can_lp_pkg::CPU_STOP3:
          // Stop-in-wait ignored here
          next_mode = stop3_slp ? can_lp_pkg::M_SLEEP : can_lp_pkg::M_PDOWN;
        can_lp_pkg::CPU_STOP2,
        can_lp_pkg::CPU_STOP1:
          next_mode = can_lp_pkg::M_PDOWN;
        default:
          next_mode = can_lp_pkg::M_PDOWN; // Illegal code treated as deepest
      endcase
    end
  end

  // Mode register and restart pulse on leaving power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m.mode    <= can_lp_pkg::M_DISABLED;
      m.restart <= 1'b0;
    end
    else
    begin
      m.mode    <= next_mode;
      m.restart <= (m.mode == can_lp_pkg::M_PDOWN) && (next_mode != can_lp_pkg::M_PDOWN);
    end
  end
endmodule : can_lp_mode_sel
`default_nettype wire

// file: core/can_lp_pkg.sv
// Package: register map, field layout, reset values and modes of the low-power and length block
package can_lp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_DATA0    = 8'h00; // First data byte; bytes 0..7 at 0x00..0x1C
  localparam logic [7:0] OFF_LENGTH   = 8'h20; // Data length register
  localparam logic [7:0] OFF_CTRL     = 8'h24; // Enable, stop-in-wait, sleep request
  localparam logic [7:0] OFF_STATUS   = 8'h28; // Sleep acknowledge and mode, read only
  localparam logic [7:0] OFF_IRQ_STAT = 8'h2C; // Sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30; // Interrupt mask
  localparam logic [7:0] OFF_TX_CMD   = 8'h34; // Write starts a frame; bit 0 remote
  // Field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SWAI   = 1;
  localparam int CTRL_SLEEP_REQUEST  = 2;
  localparam int LEN_MSB     = 3;
  localparam int IRQ_SLEEP   = 0;
  localparam int IRQ_PDOWN   = 1;
  localparam int IRQ_WAKE    = 2;
  localparam int IRQ_TXDONE  = 3;
  localparam int IRQ_W       = 4;
  // Reset values
  localparam logic [3:0]       LENGTH_RST = 4'h0;
  localparam logic [7:0]       DATA_RST   = 8'h00;
  localparam logic [2:0]       CTRL_RST   = 3'h1;
  localparam logic [IRQ_W-1:0] MASK_RST   = 4'h0;
  // Largest data byte count of a data frame
  localparam logic [3:0] MAX_BYTES = 4'h8;
  // Cycles for sleep acknowledge handshake
  localparam logic [3:0] ACK_CYCLES = 4'h4;
  // Processor modes
  typedef enum logic [2:0] {CPU_RUN, CPU_WAIT, CPU_STOP3, CPU_STOP2, CPU_STOP1} cpu_mode_t;
  // Controller modes
  typedef enum logic [1:0] {M_NORMAL, M_SLEEP, M_PDOWN, M_DISABLED} can_mode_t;
endpackage : can_lp_pkg

// file: verification/can_engine_model.sv
// Frame engine stand-in that takes offered data bytes
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
(
  input  wire logic       pclk,          // Clock
  input  wire logic       presetn,       // Async reset, active low
  input  wire logic       tx_byte_valid, // Byte offered
  input  wire logic [7:0] byte_value,    // Offered byte
  input  wire logic       slow,          // Stall every other cycle
  output logic            tx_byte_take   // Take strobe
);
  logic [7:0] got [64]; // Bytes taken, in order
  int         n;        // Count of bytes taken
  // Take strobe, toggling while slow
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_byte_take <= 1'b0;
    else
      tx_byte_take <= slow ? ~tx_byte_take : 1'b1;
  // Log each byte taken at an edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      n <= 0;
    else if (tx_byte_valid && tx_byte_take)
    begin
      got[n[5:0]] <= byte_value;
      n <= n + 1;
    end
endmodule : can_engine_model
`default_nettype wire

// file: verification/can_lowpower_and_length_tb.sv
// Testbench: registers, frame feed, interrupt and low-power modes
`timescale 1ns/1ps
`default_nettype none
module can_lowpower_and_length_tb;
  logic        pclk, presetn, psel, penable, pwrite, err, slow; // Clock, reset, bus controls
  logic [7:0]  paddr;                                        // Bus address
  logic [31:0] pwdata, prdata;                               // Bus data
  logic        pready, pslverr, tx_byte_take, tx_active, tx_remote, tx_byte_valid, engine_restart, irq;
  logic [3:0]  tx_length, seen_len;                          // Sent code, last code seen
  logic [7:0]  byte_value;                                   // Offered byte
  logic [1:0]  mode_out;                                     // Controller mode
  logic [2:0]  cpu_mode_in;                                  // Processor mode
  logic [31:0] fails = 32'h0, cmp_count = 32'h0, restarts = 32'h0;
  can_lowpower_and_length DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_mode_in(cpu_mode_in), .tx_byte_take(tx_byte_take), .tx_active(tx_active), .tx_remote(tx_remote),
    .tx_length(tx_length), .tx_byte_valid(tx_byte_valid), .byte_value(byte_value),
    .engine_restart(engine_restart), .mode_out(mode_out), .irq(irq));
  can_engine_model eng (.pclk(pclk), .presetn(presetn), .tx_byte_valid(tx_byte_valid),
    .byte_value(byte_value), .slow(slow), .tx_byte_take(tx_byte_take));
  // Clock, 4 ns period
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Restart pulses and sent length codes
  always @(posedge pclk)
  begin
    if (engine_restart === 1'b1)
      restarts <= restarts + 32'h1;
    if (tx_active === 1'b1)
      seen_len <= tx_length;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // One bus transfer, entered just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      fails++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, want);
  endtask : rd
  // Wait for a mode after its settling time
  task automatic settle(input logic [1:0] m);
    int n;
    n = 0;
    repeat (8) @(posedge pclk);
    while (mode_out !== m && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : settle
  task automatic t_regs;
    logic [31:0] r;
    rd(can_lp_pkg::OFF_LENGTH, 32'h0);
    rd(can_lp_pkg::OFF_CTRL, 32'h1);
    rd(can_lp_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h3C, 32'h0, r);
    check({31'h0, err}, 32'h1);
    for (int k = 0; k < 8; k++)
      wr(8'(4 * k), {24'h0, 8'hA0 + 8'(k)});
    for (int k = 0; k < 8; k++)
      rd(8'(4 * k), {24'h0, 8'hA0 + 8'(k)});
    wr(can_lp_pkg::OFF_LENGTH, 32'hFF);
    rd(can_lp_pkg::OFF_LENGTH, 32'hF);
    check({31'h0, err}, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  // Frames in wait mode: counts, codes, remote, stall, interrupt
  task automatic t_frames;
    logic [3:0] lens [5] = '{4'h3, 4'h8, 4'hF, 4'h5, 4'h0};
    logic [4:0] rem = 5'h08;
    int         base, cnt, n;
    cpu_mode_in <= 3'h1;
    wr(can_lp_pkg::OFF_IRQ_MASK, 32'h8);
    for (int i = 0; i < 5; i++)
    begin
      wr(can_lp_pkg::OFF_IRQ_STAT, 32'hF);
      wr(can_lp_pkg::OFF_LENGTH, {28'h0, lens[i]});
      slow <= (i == 1);
      base = eng.n;
      cnt = rem[i] ? 0 : (lens[i] > 4'h8 ? 8 : lens[i]);
      wr(can_lp_pkg::OFF_TX_CMD, {31'h0, rem[i]});
      n = 0;
      while (tx_active !== 1'b0 && n < 100)
      begin
        @(posedge pclk);
        n++;
      end
      repeat (2) @(posedge pclk);
      check(eng.n - base, cnt);
      for (int k = 0; k < cnt; k++)
        check({24'h0, eng.got[base + k]}, {24'h0, 8'hA0 + 8'(k)});
      if (cnt > 0)
        check({28'h0, seen_len}, {28'h0, lens[i]});
      check({31'h0, tx_remote}, {31'h0, rem[i]});
      check({28'h0, tx_length}, {28'h0, lens[i]});
      check({31'h0, irq}, 32'h1);
      rd(can_lp_pkg::OFF_IRQ_STAT, 32'h8);
    end
    wr(can_lp_pkg::OFF_IRQ_STAT, 32'h8);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    cpu_mode_in <= 3'h0;
    $display("t_frames done");
  endtask : t_frames
  // Mode table: processor mode, control word, expected mode
  task automatic t_modes;
    logic [2:0]  cpu [11] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
    logic [2:0]  ctl [11] = '{3'h1, 3'h5, 3'h0, 3'h1, 3'h3, 3'h7, 3'h5, 3'h7, 3'h1, 3'h7, 3'h5};
    logic [1:0]  want [11] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [31:0] r0;
    for (int i = 0; i < 11; i++)
    begin
      wr(can_lp_pkg::OFF_CTRL, {29'h0, ctl[i]});
      repeat (10) @(posedge pclk);
      cpu_mode_in <= cpu[i];
      settle(want[i]);
      check({30'h0, mode_out}, {30'h0, want[i]});
      rd(can_lp_pkg::OFF_STATUS, {28'h0, 1'b0, want[i], ctl[i][2] & ctl[i][0]});
      r0 = restarts;
      wr(can_lp_pkg::OFF_CTRL, 32'h1);
      cpu_mode_in <= 3'h0;
      settle(2'h0);
      check(restarts - r0, {31'h0, want[i] == 2'h2});
    end
    $display("t_modes done");
  endtask : t_modes
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    cpu_mode_in = 3'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_frames;
    t_modes;
    complete_run;
  end
  // Watchdog
  initial
  begin
    #20000;
    fails++;
    complete_run;
  end
endmodule : can_lowpower_and_length_tb
bind can_lowpower_and_length can_lp_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .cpu_mode_in(cpu_mode_in), .tx_byte_take(tx_byte_take), .tx_active(tx_active), .tx_remote(tx_remote),
  .tx_length(tx_length), .tx_byte_valid(tx_byte_valid), .engine_restart(engine_restart), .mode_out(mode_out));
`default_nettype wire

// file: verification/can_lp_monitor.sv
// Checker for mode and frame feed relations at the top ports
`timescale 1ns/1ps
`default_nettype none
module can_lp_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [2:0]  cpu_mode_in,
  input wire logic        tx_byte_take,
  input wire logic        tx_active,
  input wire logic        tx_remote,
  input wire logic [3:0]  tx_length,
  input wire logic        tx_byte_valid,
  input wire logic        engine_restart,
  input wire logic [1:0]  mode_out
);
  logic [2:0] ctl_sh; // Last control word written
  logic [3:0] len_sh; // Last length code written
  logic       arm;    // Sleep armed before stop3
  logic [3:0] taken;  // Bytes taken this frame
  logic       wen;    // A write lands at this edge
  assign wen = psel && penable && pwrite && pready;
  // Shadows of software writes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctl_sh <= can_lp_pkg::CTRL_RST;
      len_sh <= can_lp_pkg::LENGTH_RST;
    end
    else if (wen && paddr == can_lp_pkg::OFF_CTRL)
      ctl_sh <= pwdata[2:0];
    else if (wen && paddr == can_lp_pkg::OFF_LENGTH)
      len_sh <= pwdata[3:0];
  // Sleep choice frozen while in stop3
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      arm <= 1'b0;
    else if (cpu_mode_in != 3'h2)
      arm <= ctl_sh[2];
  // Bytes taken within one frame
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      taken <= 4'h0;
    else if (!tx_active)
      taken <= 4'h0;
    else if (tx_byte_valid && tx_byte_take)
      taken <= taken + 4'h1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Power-down left for normal
  sequence left_pd;
    (mode_out == 2'h2) ##1 (mode_out == 2'h0);
  endsequence
  a_len_code: assert property ($rose(tx_active) |-> tx_length == len_sh)
    else $error("length code differs from programmed");
  a_remote_nodata: assert property (tx_remote |-> !tx_byte_valid)
    else $error("remote frame offers data");
  a_byte_limit: assert property (taken <= 4'h8)
    else $error("more than eight bytes in a frame");
  a_run_nopd: assert property ((cpu_mode_in == 3'h0) [*8] |-> mode_out != 2'h2)
    else $error("power-down in run mode");
  a_wait_pd: assert property ((cpu_mode_in == 3'h1 && ctl_sh[1:0] == 2'h3) [*8] |-> mode_out == 2'h2)
    else $error("wait with stop-in-wait not power-down");
  a_pd_restart: assert property (left_pd |-> (engine_restart || $past(engine_restart)) or ##1 engine_restart)
    else $error("no restart on leaving power-down");
  a_wait_norm: assert property ((cpu_mode_in == 3'h1 && ctl_sh == 3'h1) [*8] |-> mode_out == 2'h0)
    else $error("wait without sleep not normal");
  a_wait_sleep: assert property ((cpu_mode_in == 3'h1 && ctl_sh == 3'h5) [*8] |-> mode_out == 2'h1)
    else $error("wait with sleep armed not sleep");
  a_deep_pd: assert property ((cpu_mode_in inside {3'h3, 3'h4} && ctl_sh[0]) [*8] |-> mode_out == 2'h2)
    else $error("deep stop not power-down");
  a_stop3_pick: assert property ((cpu_mode_in == 3'h2 && ctl_sh[0]) [*8] |-> mode_out == (arm ? 2'h1 : 2'h2))
    else $error("stop3 mode choice wrong");
endmodule : can_lp_monitor
`default_nettype wire
